// ### design/shp_acc_if.sv
// carrier between the indirect engine and the storage block
`timescale 1ns/10ps
interface shp_acc_if;
  logic                    req;     // one-cycle access pulse
  logic                    wr;      // 1 write, 0 read
  shp_pkg::shp_target_t    target;  // selected storage
  logic [7:0]              addr;    // connection memory location
  logic [9:0]              wdata;   // write word, msbs from control byte
  logic [9:0]              rdata;   // registered read word

  modport ctl (output req, output wr, output target, output addr, output wdata, input rdata);
  modport mem (input req, input wr, input target, input addr, input wdata, output rdata);
endinterface : shp_acc_if

// ### design/shp_host_port.sv
// host strobe port with direct and indirect register access
`timescale 1ns/10ps
`include "shp_regs.svh"

// Summary of operation
// - chip select low required for any access
// - select low gives mode/status, high gives indirect
// - mode write-only, status read-only, rest read-write
// - busy flag set on first indirect transfer
// - access done, busy cleared within 900 ns
// - direct registers usable during indirect sequence
// - abort bit ends running indirect sequence, clears busy; storage write issued at window open still lands
// - target bits pick register, memory read, write
// - low direction bit high reads, low writes
// - upper direction bit ignored for registers
// - FE configuration, FF clock shift, else no effect; memory takes any location
// - data byte carries the written value
// - memory stores ten bits, msbs from control
// - reads fetch control, data, address after load
// - register readback sets both low control bits
module shp_host_port (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  // host bus pins
  input  wire logic [7:0]  data_i,
  output logic      [7:0]  data_o,
  output logic             data_oe_o,
  input  wire logic        register_select_i,
  input  wire logic        wr_n_i,
  input  wire logic        rd_n_i,
  input  wire logic        cs_n_i,
  // loose status inputs from the switching core
  input  wire logic        mem_reset_busy_i,
  input  wire logic        data_loss_i,
  // register contents to the switching core
  output logic [7:0]       mode_o,
  output logic [7:0]       config_o,
  output logic [7:0]       clk_shift_o
);

  localparam logic [6:0] ACCESS_CYC = 7'(`SHP_ACCESS_CYC);  // cycles of the access window

  // ========================================================
  // state
  typedef struct packed {
    logic [11:0]         s1;      // first sync stage: cs, wr, rd, sel, data
    logic [11:0]         s2;      // second sync stage
    logic                wr_d;    // synced write strobe, delayed
    logic                rd_d;    // synced read strobe, delayed
    logic [7:0]          mode;    // mode_control
    logic [1:0]          ptr;     // indirect byte pointer
    logic [7:0]          ctl;     // indirect_access control byte
    logic [7:0]          dat;     // indirect_access data byte
    logic [7:0]          adr;     // indirect_access address byte
    logic                ibusy;   // indirect busy status flag
    shp_pkg::shp_phase_t phase;   // indirect sequence phase
    logic [6:0]          cnt;     // access window countdown
    logic [7:0]          dout;    // registered read data
  } shp_port_t;

  shp_port_t   st_r;
  shp_port_t   st_nxt;
  shp_acc_if   acc ();

  // synced pin views, read from the second stage only
  logic        cs_n_s;     // chip select
  logic        wr_n_s;     // write strobe
  logic        rd_n_s;     // read strobe
  logic        sel_s;      // register_select
  logic [7:0]  data_s;     // data bus
  logic        wr_done;    // write strobe just ended
  logic        rd_done;    // read strobe just ended
  logic        selected;   // chip selected

  assign {cs_n_s, wr_n_s, rd_n_s, sel_s, data_s} = st_r.s2;

  // ========================================================
  // helpers
  // strobe end: low last cycle, high now
  function automatic logic strobe_end(input logic prev_n, input logic now_n);
    strobe_end = !prev_n && now_n;
  endfunction : strobe_end

  // map the control and address bytes onto a storage target
  function automatic shp_pkg::shp_target_t decode_target(input logic [7:0] ctl, input logic [7:0] adr);
    if (ctl[`SHP_CTL_TSEL_HI_BIT] && ctl[`SHP_CTL_TSEL_LO_BIT]) begin
      if (adr == `SHP_ADDR_CONFIG)        decode_target = shp_pkg::TGT_CONFIG;
      else if (adr == `SHP_ADDR_CLKSHIFT) decode_target = shp_pkg::TGT_CLKSHIFT;
      else                                decode_target = shp_pkg::TGT_NONE;
    end else begin
      decode_target = shp_pkg::TGT_CONN;
    end
  endfunction : decode_target

  // write or read: target bits for memory, low direction bit for registers
  function automatic logic decode_write(input logic [7:0] ctl);
    if (ctl[`SHP_CTL_TSEL_HI_BIT] && ctl[`SHP_CTL_TSEL_LO_BIT])
      decode_write = !ctl[`SHP_CTL_DIR_LO_BIT];
    else
      decode_write = ctl[`SHP_CTL_TSEL_HI_BIT] ^ ctl[`SHP_CTL_TSEL_LO_BIT];
  endfunction : decode_write

  // ========================================================
  // strobe qualification; chip select taken from the synced level
  assign selected = !cs_n_s;
  assign wr_done  = selected && strobe_end(st_r.wr_d, wr_n_s);
  assign rd_done  = selected && strobe_end(st_r.rd_d, rd_n_s);

  // ========================================================
  // next state
  always_comb begin
    st_nxt      = st_r;
    st_nxt.s1   = {cs_n_i, wr_n_i, rd_n_i, register_select_i, data_i};
    st_nxt.s2   = st_r.s1;
    st_nxt.wr_d = wr_n_s;
    st_nxt.rd_d = rd_n_s;

    // read data mux, registered so the pins see a flop
    if (sel_s == `SHP_SEL_DIRECT) begin
      st_nxt.dout = 8'h00;
      st_nxt.dout[`SHP_STAT_IBUSY_BIT] = st_r.ibusy;
      st_nxt.dout[`SHP_STAT_MBUSY_BIT] = mem_reset_busy_i;
      st_nxt.dout[`SHP_STAT_LOSS_BIT]  = data_loss_i;
    end else begin
      case (st_r.ptr)
        2'h0:    st_nxt.dout = st_r.ctl;
        2'h1:    st_nxt.dout = st_r.dat;
        default: st_nxt.dout = st_r.adr;
      endcase
    end

    // access window countdown
    if (st_r.cnt != 7'h00) st_nxt.cnt = st_r.cnt - 7'h01;

    case (st_r.phase)
      // waiting for a control byte write
      shp_pkg::PH_IDLE: begin
        if (wr_done && sel_s == `SHP_SEL_INDIRECT) begin
          st_nxt.ctl   = data_s;
          st_nxt.ptr   = 2'h1;
          st_nxt.ibusy = 1'b1;
          st_nxt.phase = shp_pkg::PH_LOAD;
        end
      end
      // collecting data then address byte
      shp_pkg::PH_LOAD: begin
        if (wr_done && sel_s == `SHP_SEL_INDIRECT) begin
          if (st_r.ptr == 2'h1) begin
            st_nxt.dat = data_s;
            st_nxt.ptr = 2'h2;
          end else begin
            st_nxt.adr   = data_s;
            st_nxt.ptr   = 2'h0;
            st_nxt.cnt   = ACCESS_CYC;
            st_nxt.phase = shp_pkg::PH_EXEC;
          end
        end
      end
      // physical access running, busy until the window ends
      shp_pkg::PH_EXEC: begin
        if (st_r.cnt == 7'h01) begin
          st_nxt.ibusy = 1'b0;
          if (decode_write(st_r.ctl)) begin
            st_nxt.phase = shp_pkg::PH_IDLE;
          end else begin
            // result overwrites data byte and, for every target, the low control bits
            st_nxt.dat = acc.rdata[7:0];
            st_nxt.ctl = st_r.ctl | `SHP_CTL_RDBACK_ONES;
            st_nxt.ctl[`SHP_CTL_DIR_HI_BIT] = acc.rdata[9];
            st_nxt.ctl[`SHP_CTL_DIR_LO_BIT] = acc.rdata[8];
            st_nxt.phase = shp_pkg::PH_FETCH;
          end
        end
      end
      // result loaded; host fetches three bytes
      shp_pkg::PH_FETCH: begin
        if (rd_done && sel_s == `SHP_SEL_INDIRECT) begin
          st_nxt.ibusy = 1'b1;
          if (st_r.ptr == 2'h2) begin
            st_nxt.ptr   = 2'h0;
            st_nxt.cnt   = ACCESS_CYC;
            st_nxt.phase = shp_pkg::PH_RESET;
          end else begin
            st_nxt.ptr = st_r.ptr + 2'h1;
          end
        end
      end
      // mechanism reset after the last fetch
      shp_pkg::PH_RESET: begin
        if (st_r.cnt == 7'h01) begin
          st_nxt.ibusy = 1'b0;
          st_nxt.phase = shp_pkg::PH_IDLE;
        end
      end
      default: begin
        st_nxt.phase = shp_pkg::PH_IDLE;
      end
    endcase

    // direct writes take effect in any phase; abort wins over the sequence
    if (wr_done && sel_s == `SHP_SEL_DIRECT) begin
      st_nxt.mode = data_s;
      if (data_s[`SHP_MODE_ABORT_BIT]) begin
        st_nxt.phase = shp_pkg::PH_IDLE;
        st_nxt.ptr   = 2'h0;
        st_nxt.ibusy = 1'b0;
        st_nxt.cnt   = 7'h00;
      end
    end
  end

  // state register
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      st_r.s1    <= 12'hFFF;
      st_r.s2    <= 12'hFFF;
      st_r.wr_d  <= 1'b1;
      st_r.rd_d  <= 1'b1;
      st_r.mode  <= `SHP_MODE_RESET;
      st_r.ptr   <= 2'h0;
      st_r.ctl   <= `SHP_IAR_RESET;
      st_r.dat   <= `SHP_IAR_RESET;
      st_r.adr   <= `SHP_IAR_RESET;
      st_r.ibusy <= 1'b0;
      st_r.phase <= shp_pkg::PH_IDLE;
      st_r.cnt   <= 7'h00;
      st_r.dout  <= 8'h00;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ========================================================
  // storage access request, one pulse as the window opens
  assign acc.req    = st_r.phase == shp_pkg::PH_EXEC && st_r.cnt == ACCESS_CYC;
  assign acc.wr     = decode_write(st_r.ctl);
  assign acc.target = decode_target(st_r.ctl, st_r.adr);
  assign acc.addr   = st_r.adr;
  assign acc.wdata  = {st_r.ctl[`SHP_CTL_DIR_HI_BIT], st_r.ctl[`SHP_CTL_DIR_LO_BIT], st_r.dat};

  shp_store u_store (
    .core_clk_i  (core_clk_i),
    .reset_i     (reset_i),
    .acc         (acc.mem),
    .config_o    (config_o),
    .clk_shift_o (clk_shift_o)
  );

  // ========================================================
  // outputs; status register is never written, mode never read
  assign data_o    = st_r.dout;
  assign data_oe_o = selected && !rd_n_s;
  assign mode_o    = st_r.mode;

  // ========================================================
  // checks
  // pin level two edges back: covers the synchroniser as well as the gate
  a_no_drive_unsel: assert property (@(posedge core_clk_i) disable iff (reset_i)
    $past(cs_n_i, 2) |-> !data_oe_o)
    else $error("bus driven while not selected");

  a_busy_on_first: assert property (@(posedge core_clk_i) disable iff (reset_i)
    st_r.phase == shp_pkg::PH_IDLE && wr_done && sel_s && !(wr_done && !sel_s) |=> st_r.ibusy)
    else $error("busy not set by first transfer");

  a_busy_bounded: assert property (@(posedge core_clk_i) disable iff (reset_i)
    $rose(st_r.phase == shp_pkg::PH_EXEC) |-> ##[1:90] !st_r.ibusy)
    else $error("access window exceeded");

  // the mechanism reset after the last fetch has the same bound
  a_reset_bounded: assert property (@(posedge core_clk_i) disable iff (reset_i)
    $rose(st_r.phase == shp_pkg::PH_RESET) |-> ##[1:90] !st_r.ibusy)
    else $error("mechanism reset window exceeded");

  a_req_once: assert property (@(posedge core_clk_i) disable iff (reset_i)
    acc.req |=> !acc.req)
    else $error("access request longer than one cycle");

  a_abort_clears: assert property (@(posedge core_clk_i) disable iff (reset_i)
    wr_done && !sel_s && data_s[`SHP_MODE_ABORT_BIT] |=> !st_r.ibusy && st_r.ptr == 2'h0)
    else $error("abort did not cancel access");

  a_mode_any_phase: assert property (@(posedge core_clk_i) disable iff (reset_i)
    wr_done && !sel_s |=> st_r.mode == $past(data_s))
    else $error("mode write lost");

  a_ptr_wrap: assert property (@(posedge core_clk_i) disable iff (reset_i)
    st_r.ptr != 2'h3)
    else $error("byte pointer out of range");

  a_mem_wdata: assert property (@(posedge core_clk_i) disable iff (reset_i)
    acc.req && acc.target == shp_pkg::TGT_CONN |-> acc.wdata[9:8] == st_r.ctl[1:0])
    else $error("memory msbs not from control byte");

  a_reg_select: assert property (@(posedge core_clk_i) disable iff (reset_i)
    acc.req && st_r.ctl[5:4] == 2'b11 && st_r.adr == 8'hFE |-> acc.target == shp_pkg::TGT_CONFIG)
    else $error("configuration address not decoded");

endmodule : shp_host_port

// ### design/shp_pkg.sv
// types shared by the host port modules
package shp_pkg;

  // ========================================================
  // indirect sequence phase
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_LOAD,
    PH_EXEC,
    PH_FETCH,
    PH_RESET
  } shp_phase_t;

  // ========================================================
  // physical target of one indirect access
  typedef enum logic [1:0] {
    TGT_NONE,
    TGT_CONN,
    TGT_CONFIG,
    TGT_CLKSHIFT
  } shp_target_t;

endpackage : shp_pkg

// ### design/shp_regs.svh
// register offsets, field positions, reset values and timing counts of the host port
`ifndef SHP_REGS_SVH
`define SHP_REGS_SVH

// ==========================================================
// direct register select (register_select pin level)
`define SHP_SEL_DIRECT        1'b0
`define SHP_SEL_INDIRECT      1'b1

// ==========================================================
// indirect target addresses (address byte)
`define SHP_ADDR_CONFIG       8'hFE
`define SHP_ADDR_CLKSHIFT     8'hFF

// ==========================================================
// mode control fields
`define SHP_MODE_ABORT_BIT    0
`define SHP_MODE_RESET        8'h00

// ==========================================================
// status flag fields; bits 4..0 always read zero
`define SHP_STAT_IBUSY_BIT    7
`define SHP_STAT_MBUSY_BIT    6
`define SHP_STAT_LOSS_BIT     5

// ==========================================================
// control byte fields
`define SHP_CTL_TSEL_HI_BIT   5
`define SHP_CTL_TSEL_LO_BIT   4
`define SHP_CTL_DIR_HI_BIT    1
`define SHP_CTL_DIR_LO_BIT    0
`define SHP_CTL_RDBACK_ONES   8'hCC

// ==========================================================
// indirect register reset values
`define SHP_CONFIG_RESET      8'h00
`define SHP_CLKSHIFT_RESET    8'h00
`define SHP_IAR_RESET         8'h00

// ==========================================================
// timing: access window, longest time rounds down
`define SHP_CLK_NS            10
`define SHP_ACCESS_NS         900
`define SHP_ACCESS_CYC        (`SHP_ACCESS_NS / `SHP_CLK_NS)

`endif

// ### design/shp_store.sv
// connection memory plus configuration and clock shift registers
`timescale 1ns/10ps
`include "shp_regs.svh"
module shp_store (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  // access carrier
  shp_acc_if.mem           acc,
  // register contents for the switching core
  output logic [7:0]       config_o,
  output logic [7:0]       clk_shift_o
);

  // ========================================================
  // state
  typedef struct packed {
    logic [7:0] cfg;     // configuration_select
    logic [7:0] clock_shift;     // clock_shift
    logic [9:0] rdata;   // held read result
  } shp_store_t;

  shp_store_t  st_r;
  shp_store_t  st_nxt;
  logic [9:0]  conn_mem [0:255];  // connection_memory, 256 x 10, no reset

  // next state: register writes and read capture
  always_comb begin
    st_nxt = st_r;
    if (acc.req) begin
      case (acc.target)
        shp_pkg::TGT_CONFIG: begin
          if (acc.wr) st_nxt.cfg = acc.wdata[7:0];
          st_nxt.rdata = {2'b11, st_r.cfg};
        end
        shp_pkg::TGT_CLKSHIFT: begin
          if (acc.wr) st_nxt.clock_shift = acc.wdata[7:0];
          st_nxt.rdata = {2'b11, st_r.clock_shift};
        end
        shp_pkg::TGT_CONN: begin
          st_nxt.rdata = conn_mem[acc.addr];
        end
        default: begin
          st_nxt.rdata = st_r.rdata;  // unmapped address: no effect
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      st_r.cfg   <= `SHP_CONFIG_RESET;
      st_r.clock_shift   <= `SHP_CLKSHIFT_RESET;
      st_r.rdata <= 10'h000;
    end else begin
      st_r <= st_nxt;
    end
  end

  // memory write port, ten bits per location
  always_ff @(posedge core_clk_i) begin
    if (acc.req && acc.wr && acc.target == shp_pkg::TGT_CONN) begin
      conn_mem[acc.addr] <= acc.wdata;
    end
  end

  assign acc.rdata   = st_r.rdata;
  assign config_o    = st_r.cfg;
  assign clk_shift_o = st_r.clock_shift;

  // register read returns both low control bits set
  a_cfg_readback: assert property (@(posedge core_clk_i) disable iff (reset_i)
    acc.req && acc.target == shp_pkg::TGT_CONFIG |=> st_r.rdata[9:8] == 2'b11)
    else $error("config readback lacks set direction bits");

endmodule : shp_store

// ### sim/shp_host_model.sv
// host processor model driving the strobe bus of the host port
`timescale 1ns/10ps
module shp_host_model (
  // clock
  input  wire logic       core_clk_i,
  // strobe bus towards the device
  output logic [7:0]      bus_data_o,
  output logic            reg_sel_o,
  output logic            wr_n_o,
  output logic            rd_n_o,
  output logic            cs_n_o,
  // answer from the device
  input  wire logic [7:0] dev_data_i,
  input  wire logic       dev_oe_i
);
  // ========================================================
  // idle bus from time zero: strobes and select inactive
  initial begin
    bus_data_o = 8'hA5;
    reg_sel_o  = 1'b0;
    wr_n_o     = 1'b1;
    rd_n_o     = 1'b1;
    cs_n_o     = 1'b1;
  end

  // ========================================================
  // every pin change lands 1 ns after the rising edge
  task tick;
    @(posedge core_clk_i);
    #1;
  endtask : tick

  // one write strobe; data held well past the strobe end
  task write_cycle(input logic cs_n, input logic sel, input logic [7:0] val);
    tick();
    cs_n_o     = cs_n;
    reg_sel_o  = sel;
    bus_data_o = val;
    wr_n_o     = 1'b0;
    repeat (4) tick();
    wr_n_o = 1'b1;
    // the device samples through two flops, so keep data stable
    repeat (4) tick();
    cs_n_o     = 1'b1;
    bus_data_o = ~val;  // released bus must not show a stale value
    tick();
  endtask : write_cycle

  // one read strobe; answer taken while the strobe is still low
  task read_cycle(input logic cs_n, input logic sel, output logic [7:0] val, output logic oe);
    tick();
    cs_n_o    = cs_n;
    reg_sel_o = sel;
    rd_n_o    = 1'b0;
    repeat (6) tick();
    val    = dev_data_i;
    oe     = dev_oe_i;
    rd_n_o = 1'b1;
    repeat (4) tick();
    cs_n_o = 1'b1;
    tick();
  endtask : read_cycle
endmodule : shp_host_model

// ### sim/tb_top.sv
// self-checking bench for the host strobe port
`timescale 1ns/10ps
module tb_top;
  // ========================================================
  // clock, reset and pins
  logic       core_clk_i;  // 100 MHz core clock
  logic       reset_i;     // synchronous reset
  logic [7:0] bus_data;    // host data towards device
  logic       reg_sel;     // register_select level
  logic       wr_n;        // write strobe
  logic       rd_n;        // read strobe
  logic       cs_n;        // chip select
  logic       mem_busy;    // memory-reset busy level
  logic       loss;        // data loss level
  logic [7:0] dev_data;    // device read data
  logic       dev_oe;      // device drives bus
  logic [7:0] mode;        // mode_control contents
  logic [7:0] cfg;         // configuration_select contents
  logic [7:0] cks;         // clock_shift contents
  int         n_fail;      // mismatches
  int         n_compared;  // comparisons made
  int         seed;        // fixed random seed
  logic [7:0] c, s, v, d, a;
  logic [1:0] hi, k;

  shp_host_port u_dut (
    .core_clk_i        (core_clk_i),
    .reset_i           (reset_i),
    .data_i            (bus_data),
    .data_o            (dev_data),
    .data_oe_o         (dev_oe),
    .register_select_i (reg_sel),
    .wr_n_i            (wr_n),
    .rd_n_i            (rd_n),
    .cs_n_i            (cs_n),
    .mem_reset_busy_i  (mem_busy),
    .data_loss_i       (loss),
    .mode_o            (mode),
    .config_o          (cfg),
    .clk_shift_o       (cks)
  );

  shp_host_model u_host (
    .core_clk_i (core_clk_i),
    .bus_data_o (bus_data),
    .reg_sel_o  (reg_sel),
    .wr_n_o     (wr_n),
    .rd_n_o     (rd_n),
    .cs_n_o     (cs_n),
    .dev_data_i (dev_data),
    .dev_oe_i   (dev_oe)
  );

  // ========================================================
  // clock generator
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // ========================================================
  // comparison, expectations and verdict
  task check(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // status byte: busy, memory-reset busy, loss, zeros below
  function logic [7:0] exp_status(input logic ib);
    return {ib, mem_busy, loss, 5'h00};
  endfunction : exp_status

  // read-back control byte: unused bits return high, low pair from the word
  function logic [7:0] exp_ctl(input logic [7:0] ctl, input logic [1:0] msb);
    return {ctl[7:2] | 6'h33, msb};
  endfunction : exp_ctl

  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  // status read with output enable seen while reading
  task chk_status(input logic ib);
    logic [7:0] sv;
    logic       oe;
    u_host.read_cycle(1'b0, 1'b0, sv, oe);
    check("data_oe_o", 8'h01, {7'h00, oe});
    check("status_flags", exp_status(ib), sv);
  endtask : chk_status

  // the access window is 90 cycles; this wait plus the status read covers it
  task wait_window;
    repeat (84) u_host.tick();
    chk_status(1'b0);
  endtask : wait_window

  // full request sequence with status polled after the control byte and after the address byte
  task ind_write(input logic [7:0] ctl, input logic [7:0] dat, input logic [7:0] adr);
    u_host.write_cycle(1'b0, 1'b1, ctl);
    chk_status(1'b1);
    u_host.write_cycle(1'b0, 1'b1, dat);
    u_host.write_cycle(1'b0, 1'b1, adr);
    chk_status(1'b1);
    wait_window();
  endtask : ind_write

  // request then fetch of control, data and address bytes
  task ind_read(input logic [7:0] ctl, input logic [7:0] adr, input logic [1:0] msb, input logic [7:0] dat);
    logic [7:0] rv;
    logic       oe;
    ind_write(ctl, 8'($random(seed)), adr);
    u_host.read_cycle(1'b0, 1'b1, rv, oe);
    check("control byte", exp_ctl(ctl, msb), rv);
    // unselected read: no drive, and the pointer must not move
    u_host.read_cycle(1'b1, 1'b1, rv, oe);
    check("data_oe_o", 8'h00, {7'h00, oe});
    u_host.read_cycle(1'b0, 1'b1, rv, oe);
    check("data byte", dat, rv);
    u_host.read_cycle(1'b0, 1'b1, rv, oe);
    check("address byte", adr, rv);
    wait_window();
  endtask : ind_read

  // ========================================================
  // watchdog: about ten times the expected run length
  initial begin
    #400000;
    n_fail++;
    give_verdict();
  end

  // ========================================================
  // main sequence
  initial begin
    reset_i    = 1'b1;
    mem_busy   = 1'b0;
    loss       = 1'b0;
    n_fail     = 0;
    n_compared = 0;
    seed       = 32'h91DD0A13;
    repeat (6) u_host.tick();
    reset_i = 1'b0;
    check("mode_o", 8'h00, mode);
    check("config_o", 8'h00, cfg);
    check("clk_shift_o", 8'h00, cks);
    check("data_oe_o", 8'h00, {7'h00, dev_oe});
    // every combination of the loose status levels
    for (int i = 0; i < 4; i++) begin
      mem_busy = i[1];
      loss     = i[0];
      chk_status(1'b0);
    end
    mem_busy = 1'b0;
    loss     = 1'b0;
    // mode writes, then the same with chip select high
    for (int i = 0; i < 3; i++) begin
      v = 8'($random(seed)) & 8'hFE;
      u_host.write_cycle(1'b0, 1'b0, v);
      check("mode_o", v, mode);
      u_host.write_cycle(1'b1, 1'b0, ~v);
      check("mode_o", v, mode);
    end
    u_host.write_cycle(1'b1, 1'b1, 8'h30);
    chk_status(1'b0);
    // indirect registers written, upper direction bit set once
    c = 8'($random(seed));
    s = 8'($random(seed));
    ind_write(8'h30, c, 8'hFE);
    check("config_o", c, cfg);
    ind_write(8'h32, s, 8'hFF);
    check("clk_shift_o", s, cks);
    ind_read(8'h31, 8'hFE, 2'b11, c);
    ind_read(8'h33, 8'hFF, 2'b11, s);
    // register targets with an unmapped address leave configuration alone
    ind_write(8'h30, ~c, 8'h10);
    check("config_o", c, cfg);
    // memory location AA gets 200, memory location FF is not a register
    ind_write(8'h12, 8'h00, 8'hAA);
    ind_read(8'h00, 8'hAA, 2'b10, 8'h00);
    ind_write(8'h20, 8'h77, 8'hFF);
    check("clk_shift_o", s, cks);
    // random memory words through both write codes
    for (int i = 0; i < 4; i++) begin
      hi = 2'($random(seed));
      k  = ($random(seed) & 1) ? 2'b01 : 2'b10;
      d  = 8'($random(seed));
      a  = 8'($random(seed));
      ind_write({2'b00, k, 2'b00, hi}, d, a);
      ind_read(8'h00, a, hi, d);
    end
    // abort after two transfers, then a fresh sequence must start at control
    u_host.write_cycle(1'b0, 1'b1, 8'h30);
    u_host.write_cycle(1'b0, 1'b1, 8'h99);
    // plain mode write between transfers must not disturb the sequence
    u_host.write_cycle(1'b0, 1'b0, 8'h40);
    check("mode_o", 8'h40, mode);
    chk_status(1'b1);
    u_host.write_cycle(1'b0, 1'b0, 8'h01);
    check("mode_o", 8'h01, mode);
    wait_window();
    check("config_o", c, cfg);
    u_host.write_cycle(1'b0, 1'b0, 8'h00);
    v = 8'($random(seed));
    ind_write(8'h30, v, 8'hFE);
    check("config_o", v, cfg);
    give_verdict();
  end
endmodule : tb_top
